/* verification/testbench.sv */
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import insn_exec_pkg::*;

    logic        clock_i;
    logic        nrst_i;
    logic        ce_i;
    logic        insn_valid_i;
    logic [15:0] insn_i;
    logic [7:0]  file_rdata_i;
    logic        zero_flag_i;
    logic [7:0]  file_addr_o;
    logic [7:0]  file_wdata_o;
    logic        file_we_o;
    logic [15:0] table_latch_o;
    logic [7:0]  working_register_o;
    logic        zero_flag_o;
    logic        zero_we_o;
    logic        idle_cycle_o;
    logic        done_o;
    int          fails;
    int          samples_checked;
    int          cycles;

    latch_skip_xor_exec dut
    (
        .clock_i            (clock_i),
        .nrst_i             (nrst_i),
        .ce_i               (ce_i),
        .insn_valid_i       (insn_valid_i),
        .insn_i             (insn_i),
        .file_rdata_i       (file_rdata_i),
        .zero_flag_i        (zero_flag_i),
        .file_addr_o        (file_addr_o),
        .file_wdata_o       (file_wdata_o),
        .file_we_o          (file_we_o),
        .table_latch_o      (table_latch_o),
        .working_register_o (working_register_o),
        .zero_flag_o        (zero_flag_o),
        .zero_we_o          (zero_we_o),
        .idle_cycle_o       (idle_cycle_o),
        .done_o             (done_o)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // The run needs well under a hundred cycles, so a generous ceiling still catches a hang.
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Inputs change only at a rising edge, so the word is taken at the next one.
    // Results are read a nanosecond later, once they have settled.
    task automatic issue(input logic [15:0] w, input logic [7:0] rd);
        @(posedge clock_i);
        insn_valid_i <= 1'b1;
        insn_i       <= w;
        file_rdata_i <= rd;
        @(posedge clock_i);
        insn_valid_i <= 1'b0;
        #1;
    endtask

    // Valid stays high across two edges, so the second word lands in the skip slot back to back, with no gap.
    task automatic issue_pair(input logic [15:0] w0, input logic [7:0] rd0,
                              input logic [15:0] w1, input logic [7:0] rd1);
        @(posedge clock_i);
        insn_valid_i <= 1'b1;
        insn_i       <= w0;
        file_rdata_i <= rd0;
        @(posedge clock_i);
        insn_i       <= w1;
        file_rdata_i <= rd1;
        @(posedge clock_i);
        insn_valid_i <= 1'b0;
        #1;
    endtask

    task automatic run_latch_write();
        issue({LATCH_WRITE_OPC, 1'b0, 1'b0, 8'h21}, 8'hB7);
        `CHK(table_latch_o, 16'h00B7, "latch low half")
        `CHK(done_o, 1'b1, "latch done in one cycle")
        issue({LATCH_WRITE_OPC, 1'b1, 1'b0, 8'h22}, 8'h5C);
        `CHK(table_latch_o, 16'h5CB7, "latch high half")
        `CHK(zero_we_o, 1'b0, "latch leaves flags")
        `CHK(file_we_o, 1'b0, "latch writes no file")
    endtask

    task automatic run_xor();
        issue({XOR_LIT_OPC, 8'hB5}, 8'h00);
        `CHK(working_register_o, 8'hB5, "xor literal result")
        `CHK(done_o, 1'b1, "xor literal one cycle")
        `CHK(zero_we_o, 1'b1, "xor literal writes z")
        `CHK(zero_flag_o, 1'b0, "xor literal z clear")
        issue({XOR_REG_OPC, 1'b1, 8'h40}, 8'hAF);
        `CHK(file_we_o, 1'b1, "xor reg d1 writes file")
        `CHK(file_wdata_o, 8'h1A, "xor reg d1 data")
        `CHK(file_addr_o, 8'h40, "xor reg d1 address")
        `CHK(working_register_o, 8'hB5, "xor reg d1 keeps work")
        issue({XOR_REG_OPC, 1'b0, 8'h41}, 8'hB5);
        `CHK(working_register_o, 8'h00, "xor reg d0 result")
        `CHK(file_we_o, 1'b0, "xor reg d0 no file write")
        `CHK(zero_flag_o, 1'b1, "xor reg z set")
        issue({8'hB5, 8'h3C}, 8'h00);
        `CHK(done_o, 1'b0, "near opcode not xor literal")
        `CHK(working_register_o, 8'h00, "near opcode no effect")
    endtask

    task automatic run_skip();
        @(posedge clock_i);
        zero_flag_i <= 1'b1;
        issue({TEST_SKIP_OPC, 8'h10}, 8'h00);
        `CHK(zero_we_o, 1'b0, "test leaves flags")
        issue({XOR_LIT_OPC, 8'hFF}, 8'h00);
        `CHK(idle_cycle_o, 1'b1, "skipped slot idle")
        `CHK(working_register_o, 8'h00, "skipped word discarded")
        `CHK(zero_flag_o, 1'b1, "z passes through")
        issue({TEST_SKIP_OPC, 8'h11}, 8'h01);
        `CHK(done_o, 1'b1, "test decoded")
        issue({XOR_LIT_OPC, 8'h0F}, 8'h00);
        `CHK(idle_cycle_o, 1'b0, "no skip on nonzero")
        `CHK(working_register_o, 8'h0F, "next word runs")
        issue({8'h32, 8'h12}, 8'h00);
        `CHK(done_o, 1'b0, "near opcode not test")
        issue({XOR_LIT_OPC, 8'h0F}, 8'h00);
        `CHK(idle_cycle_o, 1'b0, "near opcode no skip")
        `CHK(zero_flag_o, 1'b1, "xor literal z set")
        issue_pair({TEST_SKIP_OPC, 8'h13}, 8'h00, {XOR_LIT_OPC, 8'hA5}, 8'h00);
        `CHK(idle_cycle_o, 1'b1, "back to back skip idle")
        `CHK(done_o, 1'b1, "idle slot completes")
        `CHK(working_register_o, 8'h00, "back to back word discarded")
        issue_pair({TEST_SKIP_OPC, 8'h14}, 8'h80, {XOR_LIT_OPC, 8'hA5}, 8'h00);
        `CHK(idle_cycle_o, 1'b0, "back to back no skip")
        `CHK(working_register_o, 8'hA5, "back to back next word runs")
        `CHK(zero_flag_o, 1'b0, "xor literal z clear again")
    endtask

    task automatic run_hold();
        @(posedge clock_i);
        ce_i <= 1'b0;
        issue({XOR_LIT_OPC, 8'h33}, 8'h00);
        `CHK(working_register_o, 8'hA5, "frozen while disabled")
        `CHK(done_o, 1'b0, "nothing done while disabled")
        @(posedge clock_i);
        ce_i <= 1'b1;
    endtask

    initial
    begin
        fails           = 0;
        samples_checked = 0;
        cycles          = 0;
        nrst_i          = 1'b0;
        ce_i            = 1'b1;
        insn_valid_i    = 1'b0;
        insn_i          = 16'h0000;
        file_rdata_i    = 8'h00;
        zero_flag_i     = 1'b0;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        #1;
        `CHK(table_latch_o, LATCH_RESET, "latch reset value")
        `CHK(working_register_o, WORK_RESET, "work reset value")
        run_latch_write();
        run_xor();
        run_skip();
        run_hold();
        give_verdict();
    end
endmodule

/* verilog/insn_exec_pkg.sv */
package insn_exec_pkg;
    localparam int          WORD_W          = 16;
    localparam int          DATA_W          = 8;
    localparam logic [5:0]  LATCH_WRITE_OPC = 6'h29;
    localparam logic [7:0]  TEST_SKIP_OPC   = 8'h33;
    localparam logic [7:0]  XOR_LIT_OPC     = 8'hB4;
    localparam logic [6:0]  XOR_REG_OPC     = 7'h06;
    localparam int          SEL_BIT         = 9;
    localparam int          DEST_BIT        = 8;
    localparam logic [15:0] LATCH_RESET     = 16'h0000;
    localparam logic [7:0]  WORK_RESET      = 8'h00;
    localparam logic [7:0]  FILE_ADDR_RESET = 8'h00;
    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_LATCH_WRITE,
        OP_TEST_SKIP,
        OP_XOR_LIT,
        OP_XOR_REG
    } op_kind_t;
endpackage

/* verilog/latch_skip_xor_exec.sv */
module latch_skip_xor_exec
    import insn_exec_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire logic        insn_valid_i,
    input  wire logic [15:0] insn_i,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic        zero_flag_i,
    output logic [7:0]       file_addr_o,
    output logic [7:0]       file_wdata_o,
    output logic             file_we_o,
    output logic [15:0]      table_latch_o,
    output logic [7:0]       working_register_o,
    output logic             zero_flag_o,
    output logic             zero_we_o,
    output logic             idle_cycle_o,
    output logic             done_o
);
    // The file register value arrives on file_rdata_i with the word; file_addr_o registers the address field a cycle later;
    // one execute cycle stands for the four internal phases.
    op_decode_if dif ();
    assign dif.word = insn_i;
    op_decoder u_dec (.bus(dif));

    logic [15:0] latch_reg, latch_next;
    logic [7:0]  work_reg, work_next;
    logic [7:0]  addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        we_reg, we_next;
    logic        zf_reg, zf_next;
    logic        zwe_reg, zwe_next;
    logic        skip_reg, skip_next;
    logic        done_reg, done_next;
    logic        idle_reg, idle_next;
    logic [7:0]  xor_res;
    logic        active;

    assign active = ce_i && insn_valid_i;
    assign file_addr_o = addr_reg;

    always_comb
    begin
        latch_next = latch_reg;
        work_next  = work_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        we_next    = 1'b0;
        zf_next    = zf_reg;
        zwe_next   = 1'b0;
        skip_next  = skip_reg;
        idle_next  = 1'b0;
        done_next  = 1'b0;
        xor_res    = 8'h00;
        if (active && skip_reg)
        begin
            // Prefetched word is dropped and an idle cycle runs instead.
            done_next = 1'b1;
            idle_next = 1'b1;
            skip_next = 1'b0;
        end
        else if (active)
        begin
            done_next = 1'b1;
            addr_next = insn_i[7:0];
            skip_next = 1'b0;
            case (dif.kind)
                OP_LATCH_WRITE:
                begin
                    if (insn_i[SEL_BIT])
                        latch_next[15:8] = file_rdata_i;
                    else
                        latch_next[7:0] = file_rdata_i;
                end
                OP_TEST_SKIP:
                begin
                    skip_next = (file_rdata_i == 8'h00);
                end
                OP_XOR_LIT:
                begin
                    xor_res   = work_reg ^ insn_i[7:0];
                    work_next = xor_res;
                    zf_next   = (xor_res == 8'h00);
                    zwe_next  = 1'b1;
                end
                OP_XOR_REG:
                begin
                    xor_res  = work_reg ^ file_rdata_i;
                    zf_next  = (xor_res == 8'h00);
                    zwe_next = 1'b1;
                    if (insn_i[DEST_BIT])
                    begin
                        wdata_next = xor_res;
                        we_next    = 1'b1;
                    end
                    else
                        work_next = xor_res;
                end
                default:
                begin
                    done_next = 1'b0;
                end
            endcase
        end
        if (!zwe_next && !ce_i)
            zf_next = zf_reg;
        else if (!zwe_next)
            zf_next = zero_flag_i;
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            latch_reg <= LATCH_RESET;
            work_reg  <= WORK_RESET;
            addr_reg  <= FILE_ADDR_RESET;
            wdata_reg <= WORK_RESET;
            we_reg    <= 1'b0;
            zf_reg    <= 1'b0;
            zwe_reg   <= 1'b0;
            skip_reg  <= 1'b0;
            done_reg  <= 1'b0;
            idle_reg  <= 1'b0;
        end
        else if (ce_i)
        begin
            latch_reg <= latch_next;
            work_reg  <= work_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            we_reg    <= we_next;
            zf_reg    <= zf_next;
            zwe_reg   <= zwe_next;
            skip_reg  <= skip_next;
            done_reg  <= done_next;
            idle_reg  <= idle_next;
        end
    end

    assign table_latch_o      = latch_reg;
    assign working_register_o = work_reg;
    assign file_wdata_o       = wdata_reg;
    assign file_we_o          = we_reg;
    assign zero_flag_o        = zf_reg;
    assign zero_we_o          = zwe_reg;
    assign idle_cycle_o       = idle_reg;
    assign done_o             = done_reg;

    property p_latch_high;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_LATCH_WRITE && insn_i[SEL_BIT])
        |=> (table_latch_o[15:8] == $past(file_rdata_i) &&
             table_latch_o[7:0] == $past(table_latch_o[7:0]));
    endproperty
    a_latch_high: assert property (p_latch_high) else $error("latch high wrong");

    property p_latch_low;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_LATCH_WRITE && !insn_i[SEL_BIT])
        |=> (table_latch_o[7:0] == $past(file_rdata_i) &&
             table_latch_o[15:8] == $past(table_latch_o[15:8]) && !zero_we_o);
    endproperty
    a_latch_low: assert property (p_latch_low) else $error("latch low wrong");

    property p_one_cycle;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg &&
         (dif.kind == OP_LATCH_WRITE || dif.kind == OP_XOR_LIT)) |=> done_o;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not single cycle");

    property p_skip;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_TEST_SKIP && file_rdata_i == 8'h00)
        ##1 (ce_i && active) |=> (idle_cycle_o && !file_we_o && !zero_we_o);
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing");

    property p_no_skip;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_TEST_SKIP && file_rdata_i != 8'h00)
        ##1 (ce_i && active) |=> !idle_cycle_o;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("spurious skip");

    property p_xor_lit;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && insn_i[15:8] == XOR_LIT_OPC)
        |=> (working_register_o == ($past(working_register_o) ^ $past(insn_i[7:0])));
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

    property p_xor_w;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_XOR_REG && !insn_i[DEST_BIT])
        |=> (working_register_o == ($past(working_register_o) ^ $past(file_rdata_i))
             && !file_we_o);
    endproperty
    a_xor_w: assert property (p_xor_w) else $error("xor to work wrong");

    property p_xor_f;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && active && !skip_reg && dif.kind == OP_XOR_REG && insn_i[DEST_BIT])
        |=> (file_we_o && file_wdata_o == ($past(working_register_o) ^ $past(file_rdata_i))
             && working_register_o == $past(working_register_o));
    endproperty
    a_xor_f: assert property (p_xor_f) else $error("xor to file wrong");

    property p_zero;
        @(posedge clock_i) disable iff (!nrst_i)
        zero_we_o |-> (zero_flag_o == (file_we_o ? (file_wdata_o == 8'h00)
                                                  : (working_register_o == 8'h00)));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    c_skip: cover property (@(posedge clock_i) disable iff (!nrst_i) idle_cycle_o);
    c_xor_f: cover property (@(posedge clock_i) disable iff (!nrst_i) file_we_o);
    c_zero: cover property (@(posedge clock_i) disable iff (!nrst_i) zero_we_o && zero_flag_o);
endmodule

/* verilog/op_decode_if.sv */
interface op_decode_if;
    import insn_exec_pkg::*;
    logic [15:0] word;
    op_kind_t    kind;
    modport dec (input word, output kind);
    modport use_side (output word, input kind);
endinterface

/* verilog/op_decoder.sv */
module op_decoder
    import insn_exec_pkg::*;
(
    op_decode_if.dec bus
);
    function automatic op_kind_t decode(input logic [15:0] w);
        op_kind_t k;
        k = OP_NONE;
        if (w[15:10] == LATCH_WRITE_OPC)
            k = OP_LATCH_WRITE;
        else if (w[15:8] == TEST_SKIP_OPC)
            k = OP_TEST_SKIP;
        else if (w[15:8] == XOR_LIT_OPC)
            k = OP_XOR_LIT;
        else if (w[15:9] == XOR_REG_OPC)
            k = OP_XOR_REG;
        return k;
    endfunction

    always_comb
    begin
        bus.kind = decode(bus.word);
    end
endmodule
